// >>> logic/pmtr_pkg.sv
package pmtr_pkg;
  localparam int PMTR_ADDR_W = 10;
  localparam int PMTR_WORD_W = 16;
  localparam int PMTR_DEPTH = 1024;
  localparam logic [9:0] PMTR_RESET_VECTOR = 10'h000;
  localparam logic [1:0] PMTR_LAST_PAGE = 2'h3;
  localparam logic [7:0] PMTR_TBH_RESET = 8'h00;
  localparam logic [7:0] PMTR_PCL_RESET = 8'h00;
  localparam logic [1:0] PMTR_PCH_RESET = 2'h0;
  localparam int PMTR_TABLE_CYCLES = 2;
  typedef enum logic [1:0] {
    PMTR_IDLE = 2'b00,
    PMTR_FETCH = 2'b01,
    PMTR_DONE = 2'b11
  } pmtr_state_e;
endpackage

// >>> logic/pmtr_store.sv
`timescale 1ns/10ps
`default_nettype none
module pmtr_store (
  // Clock
  input wire logic core_clk,
  // Programming write port
  input wire logic writeEn,
  input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] writeAddr,
  input wire logic [pmtr_pkg::PMTR_WORD_W-1:0] writeData,
  // Read port
  input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] readAddr,
  output logic [pmtr_pkg::PMTR_WORD_W-1:0] readData
);
  import pmtr_pkg::*;
  logic [PMTR_WORD_W-1:0] mem [0:PMTR_DEPTH-1];
  // Word array of the program store
  always_ff @(posedge core_clk) begin
    if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
    readData <= mem[readAddr];
  end
endmodule
`default_nettype wire

// >>> logic/pmtr_unit.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Holds a 1K by 16-bit program store addressed by the program counter.
// - After reset the program counter is loaded with 000H.
// - Table data anywhere in store, addressed by table pointer plus counter or last-page bits.
// - Table read writes the word's low byte to the named data register.
// - High part goes to the table high byte; all 8 bits hold word bits 15:8.
// - Current-page read address is counter bits 9:8 with pointer low byte.
// - Last-page read forces address bits 9:8 to one, base 300H.
// - Every table read takes two instruction cycles.
// - Table high byte register is read-only to software.
// - Programming address and data pass both ways on one data line.
// - Programming data moves serially on one pin, clock on another.
// - While programming, port A bits 0 and 2 are taken for data and clock.
// - Debug data pin is bidirectional; debug clock pin is input only.
// - Shared pin functions are disabled while debugging.
// - Program counter is 10 bits; only low byte software-accessible.
module pmtr_unit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Program counter control from the core
  input wire logic pcAdvance,
  input wire logic pcLoad,
  input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] pcLoadValue,
  input wire logic pclWrite,
  input wire logic [7:0] pclWriteData,
  output logic [pmtr_pkg::PMTR_ADDR_W-1:0] programCounter,
  output logic [7:0] programCounterLow,
  // Instruction fetch
  output logic [pmtr_pkg::PMTR_WORD_W-1:0] fetchWord,
  // Table read request
  input wire logic tableReadStart,
  input wire logic tableReadLastPage,
  input wire logic [7:0] tablePointerLow,
  input wire logic [7:0] tableDest,
  output logic tableBusy,
  output logic dataWriteEn,
  output logic [7:0] dataWriteAddr,
  output logic [7:0] dataWriteValue,
  output logic [7:0] tableHighByte,
  // Programming store write
  input wire logic progWriteEn,
  input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] progWriteAddr,
  input wire logic [pmtr_pkg::PMTR_WORD_W-1:0] progWriteData,
  // Mode selection
  input wire logic progMode,
  input wire logic debugMode,
  // Port A bits 0 and 2 from the general I/O, programming and debug logic
  input wire logic portAOut0,
  input wire logic portAOe0N,
  input wire logic portAOut2,
  input wire logic portAOe2N,
  input wire logic progDataOut,
  input wire logic progDataOeN,
  input wire logic debugDataOut,
  input wire logic debugDataOeN,
  // Pads
  input wire logic padA0In,
  input wire logic padA2In,
  output logic padA0Out,
  output logic padA0OeN,
  output logic padA2Out,
  output logic padA2OeN,
  // Received pin values
  output logic progSerialData,
  output logic progSerialClock,
  output logic debugDataLine,
  output logic debugClockLine,
  output logic portAIn0,
  output logic portAIn2
);
  import pmtr_pkg::*;

  pmtr_state_e state_reg, state_next;
  logic [PMTR_ADDR_W-1:0] pc_reg, pc_next;
  logic [PMTR_ADDR_W-1:0] tabAddr_reg, tabAddr_next;
  logic [7:0] dest_reg, dest_next;
  logic [7:0] tbh_reg, tbh_next;
  logic wen_reg, wen_next;
  logic [7:0] wval_reg, wval_next;
  logic [7:0] wadr_reg, wadr_next;
  logic [PMTR_ADDR_W-1:0] readAddr;
  logic [PMTR_WORD_W-1:0] readData;
  logic a0Out_reg, a0Out_next, a0Oe_reg, a0Oe_next;
  logic a2Out_reg, a2Out_next, a2Oe_reg, a2Oe_next;
  logic [5:0] inp_reg, inp_next;
  logic fetchPending_reg;

  function automatic logic [PMTR_ADDR_W-1:0] tab_addr(
    input logic lastPage, input logic [1:0] pcHigh, input logic [7:0] ptr);
    tab_addr = lastPage ? {PMTR_LAST_PAGE, ptr} : {pcHigh, ptr};
  endfunction

  // Store read port shared by fetch and table reads
  assign readAddr = (state_reg == PMTR_IDLE) ? pc_reg : tabAddr_reg;

  pmtr_store u_store (
    .core_clk(core_clk),
    .writeEn(progWriteEn),
    .writeAddr(progWriteAddr),
    .writeData(progWriteData),
    .readAddr(readAddr),
    .readData(readData)
  );

  // Program counter and table read sequencing
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    tabAddr_next = tabAddr_reg;
    dest_next = dest_reg;
    tbh_next = tbh_reg;
    wen_next = 1'b0;
    wval_next = wval_reg;
    wadr_next = wadr_reg;
    if (pcLoad) begin
      pc_next = pcLoadValue;
    end else if (pclWrite) begin
      pc_next = {pc_reg[9:8], pclWriteData};
    end else if (pcAdvance) begin
      pc_next = pc_reg + 10'h001;
    end
    unique case (state_reg)
      PMTR_IDLE: begin
        if (tableReadStart) begin
          tabAddr_next = tab_addr(tableReadLastPage, pc_reg[9:8],
                                  tablePointerLow);
          dest_next = tableDest;
          state_next = PMTR_FETCH;
        end
      end
      PMTR_FETCH: begin
        state_next = PMTR_DONE;
      end
      PMTR_DONE: begin
        wen_next = 1'b1;
        wadr_next = dest_reg;
        wval_next = readData[7:0];
        tbh_next = readData[15:8];
        state_next = PMTR_IDLE;
      end
      default: begin
        state_next = PMTR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg <= PMTR_IDLE;
      pc_reg <= PMTR_RESET_VECTOR;
      tabAddr_reg <= '0;
      dest_reg <= 8'h00;
      tbh_reg <= PMTR_TBH_RESET;
      wen_reg <= 1'b0;
      wval_reg <= 8'h00;
      wadr_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      tabAddr_reg <= tabAddr_next;
      dest_reg <= dest_next;
      tbh_reg <= tbh_next;
      wen_reg <= wen_next;
      wval_reg <= wval_next;
      wadr_reg <= wadr_next;
    end
  end

  // Fetch word register follows the store output except during table reads
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fetchPending_reg <= 1'b0;
      fetchWord <= '0;
    end else begin
      fetchPending_reg <= (state_reg == PMTR_IDLE);
      fetchWord <= fetchPending_reg ? readData : fetchWord;
    end
  end

  assign programCounter = pc_reg;
  assign programCounterLow = pc_reg[7:0];
  assign tableBusy = (state_reg != PMTR_IDLE);
  assign dataWriteEn = wen_reg;
  assign dataWriteAddr = wadr_reg;
  assign dataWriteValue = wval_reg;
  assign tableHighByte = tbh_reg;

  // Pin ownership of port A bits 0 and 2
  always_comb begin
    a0Out_next = portAOut0;
    a0Oe_next = portAOe0N;
    a2Out_next = portAOut2;
    a2Oe_next = portAOe2N;
    if (progMode) begin
      a0Out_next = progDataOut;
      a0Oe_next = progDataOeN;
      a2Out_next = 1'b0;
      a2Oe_next = 1'b1;
    end else if (debugMode) begin
      a0Out_next = debugDataOut;
      a0Oe_next = debugDataOeN;
      a2Out_next = 1'b0;
      a2Oe_next = 1'b1;
    end
    inp_next[0] = progMode & padA0In;
    inp_next[1] = progMode & padA2In;
    inp_next[2] = debugMode & ~progMode & padA0In;
    inp_next[3] = debugMode & ~progMode & padA2In;
    inp_next[4] = ~progMode & ~debugMode & padA0In;
    inp_next[5] = ~progMode & ~debugMode & padA2In;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      a0Out_reg <= 1'b0;
      a0Oe_reg <= 1'b1;
      a2Out_reg <= 1'b0;
      a2Oe_reg <= 1'b1;
      inp_reg <= 6'h00;
    end else begin
      a0Out_reg <= a0Out_next;
      a0Oe_reg <= a0Oe_next;
      a2Out_reg <= a2Out_next;
      a2Oe_reg <= a2Oe_next;
      inp_reg <= inp_next;
    end
  end

  assign padA0Out = a0Out_reg;
  assign padA0OeN = a0Oe_reg;
  assign padA2Out = a2Out_reg;
  assign padA2OeN = a2Oe_reg;
  assign progSerialData = inp_reg[0];
  assign progSerialClock = inp_reg[1];
  assign debugDataLine = inp_reg[2];
  assign debugClockLine = inp_reg[3];
  assign portAIn0 = inp_reg[4];
  assign portAIn2 = inp_reg[5];

  property p_reset_vector;
    @(posedge core_clk) !reset_n |=> pc_reg == 10'h000;
  endproperty
  a_reset_vector: assert property (p_reset_vector)
    else $error("pc not at reset vector");

  property p_two_cycles;
    @(posedge core_clk) disable iff (!reset_n)
      (state_reg == PMTR_IDLE && tableReadStart) |=> !wen_reg ##1 !wen_reg
      ##1 wen_reg;
  endproperty
  a_two_cycles: assert property (p_two_cycles)
    else $error("table read timing wrong");

  property p_last_page;
    @(posedge core_clk) disable iff (!reset_n)
      (state_reg == PMTR_IDLE && tableReadStart && tableReadLastPage)
      |=> tabAddr_reg[9:8] == 2'h3;
  endproperty
  a_last_page: assert property (p_last_page)
    else $error("last page bits not forced");

  property p_cur_page;
    @(posedge core_clk) disable iff (!reset_n)
      (state_reg == PMTR_IDLE && tableReadStart && !tableReadLastPage)
      |=> tabAddr_reg == {$past(pc_reg[9:8]), $past(tablePointerLow)};
  endproperty
  a_cur_page: assert property (p_cur_page)
    else $error("current page address wrong");

  property p_tbh_hold;
    @(posedge core_clk) disable iff (!reset_n)
      ($past(reset_n) && !wen_reg) |-> $stable(tbh_reg);
  endproperty
  a_tbh_hold: assert property (p_tbh_hold)
    else $error("table high byte changed");

  property p_dest;
    @(posedge core_clk) disable iff (!reset_n)
      (state_reg == PMTR_IDLE && tableReadStart) |=> ##2
      wadr_reg == $past(tableDest, 3);
  endproperty
  a_dest: assert property (p_dest)
    else $error("wrong destination register");

  property p_pcl_write;
    @(posedge core_clk) disable iff (!reset_n)
      (!pcLoad && pclWrite) |=> pc_reg == {$past(pc_reg[9:8]),
      $past(pclWriteData)};
  endproperty
  a_pcl_write: assert property (p_pcl_write)
    else $error("low byte write wrong");

  property p_prog_pins;
    @(posedge core_clk) disable iff (!reset_n)
      progMode |=> padA2OeN && padA0Out == $past(progDataOut);
  endproperty
  a_prog_pins: assert property (p_prog_pins)
    else $error("programming pins not taken");

  property p_debug_shared;
    @(posedge core_clk) disable iff (!reset_n)
      debugMode |=> !portAIn0 && !portAIn2;
  endproperty
  a_debug_shared: assert property (p_debug_shared)
    else $error("shared pin active in debug");

  c_cur: cover property (@(posedge core_clk) disable iff (!reset_n)
    tableReadStart && !tableReadLastPage && state_reg == PMTR_IDLE);
  c_last: cover property (@(posedge core_clk) disable iff (!reset_n)
    tableReadStart && tableReadLastPage && state_reg == PMTR_IDLE);
  c_prog: cover property (@(posedge core_clk) disable iff (!reset_n)
    progMode && progWriteEn);
  c_dbg: cover property (@(posedge core_clk) disable iff (!reset_n)
    debugMode && !progMode);
endmodule
`default_nettype wire

// >>> bench/pmtr_prog_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmtr_prog_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Load control
  input wire logic loadGo,
  output logic loadDone,
  // Store write
  output logic progWriteEn,
  output logic [pmtr_pkg::PMTR_ADDR_W-1:0] progWriteAddr,
  output logic [pmtr_pkg::PMTR_WORD_W-1:0] progWriteData
);
  import pmtr_pkg::*;
  logic [10:0] cnt;
  // Downloads every word in turn, one word per cycle
  always @(posedge core_clk) begin
    if (!reset_n || !loadGo) begin
      cnt <= 11'h000;
    end else if (!cnt[10]) begin
      cnt <= cnt + 11'h001;
    end
  end
  assign progWriteEn = loadGo && reset_n && !cnt[10];
  assign progWriteAddr = cnt[9:0];
  assign progWriteData = {~cnt[7:0], cnt[9:2]};
  assign loadDone = cnt[10];
endmodule
`default_nettype wire

// >>> bench/pmtr_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pmtr_unit_tb;
  import pmtr_pkg::*;
  logic core_clk, reset_n, pcAdvance, pcLoad, pclWrite, loadGo, loadDone;
  logic tableReadStart, tableReadLastPage, progWriteEn, progMode, debugMode;
  logic portAOut0, portAOe0N, portAOut2, portAOe2N, progDataOut, progDataOeN;
  logic debugDataOut, debugDataOeN, padA0In, padA2In, tableBusy, dataWriteEn;
  logic padA0Out, padA0OeN, padA2Out, padA2OeN, progSerialData;
  logic progSerialClock, debugDataLine, debugClockLine, portAIn0, portAIn2;
  logic [9:0] pcLoadValue, progWriteAddr, programCounter;
  logic [7:0] pclWriteData, programCounterLow, tablePointerLow, tableDest;
  logic [7:0] dataWriteAddr, dataWriteValue, tableHighByte;
  logic [15:0] progWriteData, fetchWord;
  // Rows: last page, counter page, pointer, destination
  logic [18:0] rows [7] = '{19'h00010, 19'h15A11, 19'h2FF12, 19'h40613,
                            19'h50014, 19'h6FF15, 19'h38016};
  int fail_count = 0;
  int num_checks = 0;

  pmtr_unit pmtr_unit_i (.*);
  pmtr_prog_model pmtr_prog_model_i (.*);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic tread(input logic [18:0] r, input logic hold);
    int n;
    logic [9:0] ad;
    logic [7:0] hb;
    ad = r[18] ? {2'h3, r[15:8]} : {r[17:16], r[15:8]};
    hb = ~ad[7:0];
    tableReadLastPage = r[18];
    tablePointerLow = r[15:8];
    tableDest = r[7:0];
    tableReadStart = 1'b1;
    tick(1);
    check(tableBusy, 1'b1);
    tableReadStart = hold;
    tablePointerLow = ~r[15:8];
    tableDest = ~r[7:0];
    n = 0;
    while (dataWriteEn !== 1'b1 && n < 8) begin
      tick(1);
      tableReadStart = 1'b0;
      n++;
    end
    if (n == 8) begin
      fail_count++;
      stop_test;
    end
    check(16'(n), 16'(PMTR_TABLE_CYCLES));
    check(dataWriteAddr, r[7:0]);
    check(dataWriteValue, ad[9:2]);
    check(tableHighByte, hb);
    tick(1);
    check(dataWriteEn, 1'b0);
  endtask

  initial begin
    {reset_n, pcAdvance, pcLoad, pclWrite, loadGo, tableReadStart} = '0;
    {tableReadLastPage, progMode, debugMode, portAOut0, portAOut2} = '0;
    {progDataOut, debugDataOut, padA0In, padA2In} = '0;
    {portAOe0N, portAOe2N, progDataOeN, debugDataOeN} = 4'hF;
    pcLoadValue = 10'h000;
    pclWriteData = 8'h00;
    tablePointerLow = 8'h00;
    tableDest = 8'h00;
    tick(10);
    reset_n = 1'b1;
    check(programCounter, 10'h000);
    check(tableHighByte, 8'h00);
    check(padA0OeN, 1'b1);
    loadGo = 1'b1;
    for (int i = 0; i < 1100 && loadDone !== 1'b1; i++) begin
      tick(1);
    end
    if (loadDone !== 1'b1) begin
      fail_count++;
      stop_test;
    end
    loadGo = 1'b0;
    tick(1);
    check(fetchWord, 16'hFF00);
    foreach (rows[i]) begin
      pcLoadValue = {rows[i][17:16], 8'h33};
      pcLoad = 1'b1;
      tick(1);
      pcLoad = 1'b0;
      check(programCounter, pcLoadValue);
      tread(rows[i], 1'b0);
    end
    $display("Table rows done");
    tread(19'h3C120, 1'b1);
    pclWriteData = 8'h7E;
    pclWrite = 1'b1;
    tick(1);
    pclWrite = 1'b0;
    check(programCounter, 10'h37E);
    pcAdvance = 1'b1;
    tick(2);
    pcAdvance = 1'b0;
    check(programCounterLow, 8'h80);
    check(tableHighByte, 8'h3E);
    $display("Refused read and holding done");
    {progMode, debugMode, progDataOut, progDataOeN} = 4'hE;
    {padA2In, portAOe0N, portAOut2, portAOe2N} = 4'hA;
    tick(2);
    check({padA0Out, padA0OeN, padA2OeN, progSerialClock, portAIn2,
           padA2Out}, 6'h2C);
    {progMode, debugDataOeN, padA0In, debugDataOut} = 4'h7;
    tick(2);
    check({padA0OeN, debugDataLine, debugClockLine, progSerialData, portAIn0,
           padA0Out, padA2OeN}, 7'h73);
    debugMode = 1'b0;
    tick(2);
    check({padA0Out, padA0OeN, portAIn0, portAIn2, padA2Out, padA2OeN},
          6'h0E);
    $display("Pin sharing done");
    reset_n = 1'b0;
    tick(1);
    reset_n = 1'b1;
    check(programCounter, 10'h000);
    check(tableHighByte, 8'h00);
    tick(3);
    check(fetchWord, 16'hFF00);
    $display("Second reset done");
    stop_test;
  end
endmodule
`default_nettype wire
